/* File: src/swlc_top.sv */
`default_nettype none
// Notes on behaviour
// R01 - Latch code selects exactly one of 128 taps
// R02 - Code zero puts wiper at B end
// R03 - Each code step moves wiper one tap up
// R04 - Wiper follows latch, never the shift register
// R05 - Select low enables shifting and serial output
// R06 - Select low: shift one bit per clock rise
// R07 - Output shows bit entered seven shifts earlier
// R08 - Only last seven bits reach the latch
// R09 - Select rise loads all seven bits at once
// R10 - Reset low forces midscale, clears output register
// R11 - Reset release with select high holds 40H
// R12 - Shutdown opens A, ties wiper to B
// R13 - Shutdown turns open-drain output off
// R14 - Host holds select low across whole chain
// R15 - Latch contents survive shutdown unchanged
// R16 - Seven stages, output from last, shift edges only
module swlc_top #(
    parameter int WIPER_BITS = swlc_pkg::WIPER_BITS,
    parameter int TAP_COUNT  = swlc_pkg::TAP_COUNT
) (
    // System clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // Serial link, clocked by the host
    input  wire logic                   serClk,
    input  wire swlc_pkg::swlc_serial_t serialIn,
    output swlc_pkg::swlc_sdo_t         sdo,
    // Control pins
    input  wire logic                   midscaleResetN,
    input  wire logic                   powerDownN,
    // Resistor control
    output swlc_pkg::swlc_wiper_t       wiper,
    output logic [TAP_COUNT-1:0]        tapSelect,
    output logic                        latchLoaded
);

    // =================================================================
    // Helpers
    function automatic logic [TAP_COUNT-1:0] tapDecode(
        input logic [WIPER_BITS-1:0] code
    );
        logic [TAP_COUNT-1:0] oneHot;
        oneHot = '0;
        oneHot[code] = 1'b1;
        return oneHot;
    endfunction : tapDecode

    function automatic logic risingAgreed(
        input logic prev,
        input logic curr
    );
        return !prev && curr;
    endfunction : risingAgreed

    // Next latch value: midscale request outranks a frame ending at the same edge
    function automatic logic [WIPER_BITS-1:0] nextCode(
        input logic [WIPER_BITS-1:0] held,
        input logic [WIPER_BITS-1:0] word,
        input logic                  midscaleN,
        input logic                  load
    );
        logic [WIPER_BITS-1:0] code;
        code = held; // R15
        if (!midscaleN) begin
            code = swlc_pkg::MIDSCALE_CODE; // R10 R11
        end else if (load) begin
            code = word; // R08 R09
        end
        return code;
    endfunction : nextCode

    // =================================================================
    // Link domain: serial shift register
    logic [WIPER_BITS-1:0] serialShiftRegister_q;
    logic [WIPER_BITS-1:0] serialShiftRegister_d;
    logic                  sdoBit_q;
    logic                  linkClearN;

    always_comb begin
        serialShiftRegister_d = {serialShiftRegister_q[WIPER_BITS-2:0], serialIn.sdi}; // R06
    end

    // Older bits fall off the top end
    always_ff @(posedge serClk or negedge reset_n) begin
        if (!reset_n) begin
            serialShiftRegister_q <= swlc_pkg::ZERO_CODE;
        end else if (!serialIn.csN) begin // R05
            serialShiftRegister_q <= serialShiftRegister_d; // R06 R08 R16
        end
    end

    assign linkClearN = reset_n && midscaleResetN;

    // Open-drain stage, forced off or cleared without a clock
    always_ff @(posedge serClk or negedge linkClearN or negedge powerDownN) begin
        if (!powerDownN) begin
            sdoBit_q <= 1'b1; // R13
        end else if (!linkClearN) begin
            sdoBit_q <= 1'b0; // R10
        end else if (!serialIn.csN) begin // R05
            sdoBit_q <= serialShiftRegister_q[WIPER_BITS-1]; // R07 R16
        end
    end

    // Pad never drives high; release means pulled-up high
    assign sdo = '{sdoOut: 1'b0,
                   sdoOeN: sdoBit_q};

    // =================================================================
    // Pin synchronisation into the system domain
    logic [swlc_pkg::PIN_SYNC_BITS-1:0] pinAsync;
    logic [swlc_pkg::PIN_SYNC_BITS-1:0] pinLevel;
    logic                               csLevel;
    logic                               midscaleLevelN;
    logic                               powerDownLevelN;

    assign pinAsync[swlc_pkg::PIN_CS_POS]  = serialIn.csN;
    assign pinAsync[swlc_pkg::PIN_RST_POS] = midscaleResetN;
    assign pinAsync[swlc_pkg::PIN_PD_POS]  = powerDownN;

    swlc_pin_sync #(
        .WIDTH     (swlc_pkg::PIN_SYNC_BITS),
        .RESET_VAL (swlc_pkg::PIN_IDLE)
    ) u_pin_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .pinAsync  (pinAsync),
        .pinLevel  (pinLevel)
    );

    assign csLevel         = pinLevel[swlc_pkg::PIN_CS_POS];
    assign midscaleLevelN  = pinLevel[swlc_pkg::PIN_RST_POS];
    assign powerDownLevelN = pinLevel[swlc_pkg::PIN_PD_POS];

    // =================================================================
    // Shift word brought into the system domain
    logic [WIPER_BITS-1:0] shiftWordMeta_q;
    logic [WIPER_BITS-1:0] shiftWord_q;

    // Word is frozen while select is high; two stages settle it before use
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftWordMeta_q <= swlc_pkg::ZERO_CODE;
            shiftWord_q     <= swlc_pkg::ZERO_CODE;
        end else begin
            shiftWordMeta_q <= serialShiftRegister_q;
            shiftWord_q     <= shiftWordMeta_q;
        end
    end

    // =================================================================
    // Frame tracking
    swlc_pkg::swlc_load_t loadState_q;
    swlc_pkg::swlc_load_t loadState_d;
    logic                 csPrev_q;
    logic                 csRise;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            csPrev_q <= 1'b1;
        end else begin
            csPrev_q <= csLevel;
        end
    end

    assign csRise = risingAgreed(csPrev_q, csLevel);

    always_comb begin
        loadState_d = loadState_q;
        case (loadState_q)
            swlc_pkg::LOAD_IDLE: begin
                if (!csLevel) begin
                    loadState_d = swlc_pkg::LOAD_FRAME;
                end
            end
            swlc_pkg::LOAD_FRAME: begin
                if (csRise) begin
                    loadState_d = swlc_pkg::LOAD_HELD;
                end
            end
            swlc_pkg::LOAD_HELD: begin
                loadState_d = csLevel ? swlc_pkg::LOAD_IDLE : swlc_pkg::LOAD_FRAME;
            end
            default: begin
                loadState_d = swlc_pkg::LOAD_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            loadState_q <= swlc_pkg::LOAD_IDLE;
        end else begin
            loadState_q <= loadState_d;
        end
    end

    // =================================================================
    // Wiper code latch
    logic [WIPER_BITS-1:0] wiperCodeLatch_q;
    logic                  loadNow;
    logic                  latchLoaded_q;

    // Settled word is taken only once select has risen
    assign loadNow = (loadState_q == swlc_pkg::LOAD_FRAME) && csRise;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wiperCodeLatch_q <= swlc_pkg::MIDSCALE_CODE;
        end else begin
            wiperCodeLatch_q <= nextCode(wiperCodeLatch_q, shiftWord_q,
                                         midscaleLevelN, loadNow); // R09
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            latchLoaded_q <= 1'b0;
        end else begin
            latchLoaded_q <= loadNow && midscaleLevelN;
        end
    end

    // =================================================================
    // Resistor network control
    swlc_pkg::swlc_wiper_t wiper_q;
    logic [TAP_COUNT-1:0]  tapSelect_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wiper_q.aTermOpen <= 1'b0;
            wiper_q.wiperToB  <= 1'b0;
            wiper_q.shutdown  <= 1'b0;
            wiper_q.code      <= swlc_pkg::MIDSCALE_CODE;
        end else begin
            wiper_q.aTermOpen <= !powerDownLevelN; // R12
            wiper_q.wiperToB  <= !powerDownLevelN; // R12
            wiper_q.shutdown  <= !powerDownLevelN;
            wiper_q.code      <= nextCode(wiperCodeLatch_q, shiftWord_q,
                                          midscaleLevelN, loadNow); // R04
        end
    end

    // Tap zero is the B end; shutdown parks the wiper there
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tapSelect_q <= tapDecode(swlc_pkg::MIDSCALE_CODE);
        end else if (!powerDownLevelN) begin
            tapSelect_q <= tapDecode(swlc_pkg::ZERO_CODE); // R12
        end else begin
            tapSelect_q <= tapDecode(nextCode(wiperCodeLatch_q, shiftWord_q,
                                              midscaleLevelN, loadNow)); // R01 R02 R03 R04
        end
    end

    assign wiper       = wiper_q;
    assign tapSelect   = tapSelect_q;
    assign latchLoaded = latchLoaded_q;

endmodule : swlc_top
`default_nettype wire

/* File: src/swlc_pkg.sv */
`default_nettype none
// =====================================================================
// Shared constants and carriers
package swlc_pkg;

    // =================================================================
    // Wiper latch geometry
    localparam int          WIPER_BITS    = 7;
    localparam int          TAP_COUNT     = 128;
    localparam logic [6:0]  MIDSCALE_CODE = 7'h40;
    localparam logic [6:0]  ZERO_CODE     = 7'h00;

    // =================================================================
    // Pin synchroniser layout and idle levels
    localparam int          PIN_SYNC_BITS = 3;
    localparam int          PIN_CS_POS    = 2;
    localparam int          PIN_RST_POS   = 1;
    localparam int          PIN_PD_POS    = 0;
    localparam logic [2:0]  PIN_IDLE      = 3'h7;

    // =================================================================
    // Carriers
    typedef struct packed {
        logic       csN;
        logic       sdi;
    } swlc_serial_t;

    typedef struct packed {
        logic       sdoOut;
        logic       sdoOeN;
    } swlc_sdo_t;

    typedef struct packed {
        logic       aTermOpen;
        logic       wiperToB;
        logic       shutdown;
        logic [6:0] code;
    } swlc_wiper_t;

    typedef enum logic [1:0] {
        LOAD_IDLE,
        LOAD_FRAME,
        LOAD_HELD
    } swlc_load_t;

endpackage : swlc_pkg
`default_nettype wire

/* File: src/swlc_pin_sync.sv */
`default_nettype none
// =====================================================================
// Three-stage pin synchroniser with agreement filter
module swlc_pin_sync #(
    parameter int               WIDTH     = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Asynchronous pins
    input  wire logic [WIDTH-1:0] pinAsync,
    // Filtered levels
    output logic      [WIDTH-1:0] pinLevel
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
        end else begin
            stage1_q <= pinAsync;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    level_q[i] <= stage3_q[i];
                end
            end
        end
    end

    assign pinLevel = level_q;

endmodule : swlc_pin_sync
`default_nettype wire

/* File: tb/swlc_host_model.sv */
`default_nettype none
// ==========================================================
// Host driving the serial chain; link clock runs only in frames
module swlc_host_model (
    // Link outputs
    output var logic                   serClk,
    output var swlc_pkg::swlc_serial_t serialIn,
    // Serial output level seen at the pull-up
    input  wire logic                  sdoWire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [13:0] seenQ;
    initial begin
        serClk = 1'b0;
        serialIn = '{csN: 1'b1, sdi: 1'b0};
        seenQ = '0;
    end
    // MSB first, select held low for the whole word
    task automatic frame(input logic [13:0] bits, input int n);
        serialIn.csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serialIn.sdi = bits[i];
            #7.5 serClk = 1'b1;
            #0.1 seenQ = {seenQ[12:0], sdoWire};
            #7.4 serClk = 1'b0;
        end
        #7.5 serialIn.csN = 1'b1;
        serialIn.sdi = ~serialIn.sdi;
        #100;
    endtask : frame
endmodule : swlc_host_model
`default_nettype wire

/* File: tb/swlc_chk.sv */
`default_nettype none
// ==========================================================
// Port checker
module swlc_chk #(
    parameter int TAP_COUNT = swlc_pkg::TAP_COUNT
) (
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    // Pins
    input wire swlc_pkg::swlc_serial_t serialIn,
    input wire swlc_pkg::swlc_sdo_t    sdo,
    input wire logic                   midscaleResetN,
    input wire logic                   powerDownN,
    // Resistor control
    input wire swlc_pkg::swlc_wiper_t  wiper,
    input wire logic [TAP_COUNT-1:0]   tapSelect,
    input wire logic                   latchLoaded
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_onehot; $onehot(tapSelect); endproperty
    a_onehot: assert property (p_onehot)
        else $error("tap select not one-hot");
    property p_tap; !wiper.shutdown |-> tapSelect == (TAP_COUNT'(1) << wiper.code); endproperty
    a_tap: assert property (p_tap)
        else $error("tap does not follow code");
    property p_power_down_n; wiper.shutdown |-> tapSelect == 1 && wiper.aTermOpen && wiper.wiperToB;
    endproperty
    a_power_down_n: assert property (p_power_down_n)
        else $error("shutdown state wrong");
    property p_pd_sdo; !powerDownN |-> sdo.sdoOeN; endproperty
    a_pd_sdo: assert property (p_pd_sdo)
        else $error("serial output on in shutdown");
    property p_kept; $changed(wiper.code) |-> latchLoaded || wiper.code == 7'h40; endproperty
    a_kept: assert property (p_kept)
        else $error("code changed without load");
    property p_refused; !midscaleResetN [*6] |-> !latchLoaded && wiper.code == 7'h40; endproperty
    a_refused: assert property (p_refused)
        else $error("load during midscale reset");
    property p_pulse; latchLoaded |=> !latchLoaded; endproperty
    a_pulse: assert property (p_pulse)
        else $error("load pulse too long");
    property p_load_cs; latchLoaded |-> $past(serialIn.csN, 1) && $past(serialIn.csN, 3);
    endproperty
    a_load_cs: assert property (p_load_cs)
        else $error("load without select high");
    c_load: cover property (latchLoaded);
    c_power_down_n: cover property (wiper.shutdown);
    c_mid: cover property (!midscaleResetN ##1 midscaleResetN);
endmodule : swlc_chk
bind swlc_top swlc_chk #(.TAP_COUNT(TAP_COUNT)) i_swlc_chk (.sys_clk(sys_clk),
    .reset_n(reset_n), .serialIn(serialIn), .sdo(sdo), .midscaleResetN(midscaleResetN),
    .powerDownN(powerDownN), .wiper(wiper), .tapSelect(tapSelect), .latchLoaded(latchLoaded));
`default_nettype wire

/* File: tb/swlc_tb_top.sv */
`default_nettype none
module swlc_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [13:0] bits;
        logic [4:0]  n;
        logic [6:0]  code;
        logic [6:0]  seen;
    } swlc_row_t;
    logic                   sys_clk, reset_n, serClk, midscaleResetN, powerDownN, latchLoaded;
    wire logic              sdoWire;
    swlc_pkg::swlc_serial_t serialIn;
    swlc_pkg::swlc_sdo_t    sdo;
    swlc_pkg::swlc_wiper_t  wiper;
    logic [127:0]           tapSelect;
    int                     err_count, total_checks, cycles, loads;
    swlc_row_t rows [5] = '{'{14'h0000, 5'h07, 7'h00, 7'h00}, '{14'h007F, 5'h07, 7'h7F, 7'h00},
        '{14'h0001, 5'h07, 7'h01, 7'h7F}, '{14'h1555, 5'h0E, 7'h55, 7'h2A},
        '{14'h01BC, 5'h09, 7'h3C, 7'h57}};
    assign sdoWire = sdo.sdoOeN ? 1'b1 : sdo.sdoOut;
    swlc_top i_swlc_top (.sys_clk(sys_clk), .reset_n(reset_n), .serClk(serClk),
        .serialIn(serialIn), .sdo(sdo), .midscaleResetN(midscaleResetN),
        .powerDownN(powerDownN), .wiper(wiper), .tapSelect(tapSelect), .latchLoaded(latchLoaded));
    swlc_host_model i_swlc_host_model (.serClk(serClk), .serialIn(serialIn), .sdoWire(sdoWire));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (latchLoaded === 1'b1) loads++;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic expect_tap(input logic [6:0] code);
        check("code", wiper.code, code);
        check("tap", tapSelect, 128'h1 << code);
    endtask : expect_tap
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    initial begin
        reset_n = 1'b1;
        midscaleResetN = 1'b1;
        powerDownN = 1'b1;
        #1 reset_n = 1'b0;
        step(5);
        reset_n = 1'b1;
        step(2);
        expect_tap(7'h40);
        check("sdo clear", sdo.sdoOeN, 1'b0);
        $display("test reset done");
        step(6);
        foreach (rows[i]) begin
            i_swlc_host_model.frame(rows[i].bits, int'(rows[i].n));
            step(1);
            expect_tap(rows[i].code);
            check("sdo bits", i_swlc_host_model.seenQ[6:0], rows[i].seen);
        end
        check("loads", loads, 5);
        $display("test rows done");
        powerDownN = 1'b0;
        step(8);
        check("power_down_n", {wiper.aTermOpen, wiper.wiperToB, wiper.shutdown}, 3'h7);
        check("power_down_n tap", tapSelect, 128'h1);
        check("sdo off", sdoWire, 1'b1);
        powerDownN = 1'b1;
        step(8);
        expect_tap(7'h3C);
        $display("test shutdown done");
        midscaleResetN = 1'b0;
        step(8);
        expect_tap(7'h40);
        i_swlc_host_model.frame(14'h0022, 7);
        check("no load", loads, 5);
        midscaleResetN = 1'b1;
        step(8);
        expect_tap(7'h40);
        $display("test midscale done");
        i_swlc_host_model.frame(14'h0011, 7);
        step(1);
        reset_n = 1'b0;
        step(2);
        expect_tap(7'h40);
        reset_n = 1'b1;
        step(8);
        i_swlc_host_model.frame(14'h006B, 7);
        step(1);
        expect_tap(7'h6B);
        $display("test second reset done");
        give_verdict();
    end
endmodule : swlc_tb_top
`default_nettype wire
